/* File: sps_pkg.sv */
// ****************************************************************
// constants of the serial port status block
// ****************************************************************
package sps_pkg;

    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_DATA     = 12'hf60;
    localparam logic [11:0] IDX_CONTROL  = 12'hf61;
    localparam logic [11:0] IDX_STATUS   = 12'hf62;
    localparam logic [11:0] IDX_FORMAT   = 12'hf63;
    localparam logic [11:0] IDX_MASK     = 12'hf6a;

    // reset values
    localparam logic [7:0]  STATUS_RST   = 8'h01;
    localparam logic [7:0]  CONTROL_RST  = 8'h00;
    localparam logic [7:0]  FORMAT_RST   = 8'h00;
    localparam logic [7:0]  MASK_RST     = 8'h80;

    // status fields
    localparam int          ST_IRQ       = 7;
    localparam int          ST_OVR       = 6;
    localparam int          ST_COL       = 5;
    localparam int          ST_ABT       = 4;
    localparam int          ST_ACT       = 1;
    localparam int          ST_SEL       = 0;
    localparam logic [7:0]  STICKY_BITS  = 8'hf0;

    // control fields
    localparam int          CT_REQUEST_FORWARD_ENABLE      = 7;
    localparam int          CT_STR       = 6;
    localparam int          CT_POL       = 3;
    localparam int          CT_MST       = 1;
    localparam int          CT_EN        = 0;

    // format fields: character length in bits 4..2, 0 means eight
    localparam int          FM_LEN_HI    = 4;
    localparam int          FM_LEN_LO    = 2;
    localparam logic [3:0]  FULL_CHAR    = 4'h8;

    // pin sampling
    localparam int          SYNC_STAGES  = 3;

    typedef enum logic [1:0]
    {
        LNK_IDLE  = 2'b01,
        LNK_SHIFT = 2'b10
    } sps_link_t;

endpackage : sps_pkg

/* File: sps_reg_if.sv */
`timescale 1ns/1ps
// ****************************************************************
// register access between bus slave and status core
// ****************************************************************
interface sps_reg_if;
    logic        wr;
    logic [11:0] idx;
    logic [7:0]  wdata;
    logic [7:0]  rdata;

    modport bus
    (
        output wr,
        output idx,
        output wdata,
        input  rdata
    );

    modport core
    (
        input  wr,
        input  idx,
        input  wdata,
        output rdata
    );
endinterface : sps_reg_if

/* File: sps_sync.sv */
`timescale 1ns/1ps
// ****************************************************************
// pin sampler: three stages, change taken once stages two and three agree
// ****************************************************************
module sps_sync #(
    parameter int          W   = 2,
    parameter logic [1:0]  RST = 2'b00
)
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // pins in, filtered levels out
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            // first stage feeds only the second
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    s1[g]    <= RST[g];
                    s2[g]    <= RST[g];
                    s3[g]    <= RST[g];
                    level[g] <= RST[g];
                end
                else
                begin
                    s1[g] <= pin[g];
                    s2[g] <= s1[g];
                    s3[g] <= s2[g];
                    if (s2[g] == s3[g])
                        level[g] <= s3[g];
                end
            end
        end
    endgenerate
endmodule : sps_sync

/* File: sps_wb.sv */
`timescale 1ns/1ps
// ****************************************************************
// classic wishbone slave, one wait state
// ****************************************************************
module sps_wb
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // wishbone
    input  wire logic [15:0] adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        we_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // register side
    sps_reg_if.bus           rg
);
    logic req;

    assign req      = cyc_i & stb_i;
    assign rg.idx   = adr_i[13:2];
    assign rg.wdata = dat_i[7:0];
    // write lands on the edge the master sees ack
    assign rg.wr    = req & we_i & sel_i[0] & ack_o & (adr_i[15:14] == 2'b00);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ack_o <= 1'b0;
        else
            ack_o <= req & ~ack_o;
    end

    // upper lanes read zero; unmapped indices read zero through the core, upper address ranges read zero here
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            dat_o <= 32'h0000_0000;
        else if (req & ~ack_o)
            dat_o <= (adr_i[15:14] == 2'b00) ? {24'h00_0000, rg.rdata}
                                             : 32'h0000_0000;
    end
endmodule : sps_wb

/* File: sps_top.sv */
`timescale 1ns/1ps
// Contract
// - port off holds whole status register at its reset value
// - writing one clears pending, overrun, collision, abort; zero leaves them
// - enabled: force bit or finished transaction sets pending bit 7
// - bit 7 reads one while a request is pending
// - bit 6 overrun flag sticks until software clears it
// - bit 5 collision flag sticks after a mode fault
// - slave: select released after at least one bit, before full character, sets abort bit 4
// - abort also sets the pending flag
// - bit 1 reads one while a transfer is in progress
// - slave: bit 0 shows select level, low when asserted
// - master: bit 0 carries no defined meaning
// - data write during transfer is dropped and sets overrun
// - requests reach the interrupt line only while forwarding enabled
// - writing one to pending bit also clears the force bit
module sps_top
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // wishbone slave
    input  wire logic [15:0] ADR_I,
    input  wire logic [31:0] DAT_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic        WE_I,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    // serial link pins
    input  wire logic        SCK_IN,
    input  wire logic        SS_N_IN,
    // rest of the unit
    input  wire logic        MASTER_DONE,
    input  wire logic        MODE_FAULT,
    input  wire logic [7:0]  SHIFT_DATA,
    output logic             DATA_LOAD,
    output logic      [7:0]  DATA_BYTE,
    output logic      [7:0]  CONTROL_OUT,
    output logic      [7:0]  FORMAT_OUT,
    // interrupt
    output logic             IRQ
);
    // ****************************************************************
    // bus slave and pin sampling
    // ****************************************************************
    sps_reg_if rg ();

    sps_wb u_wb
    (
        .clk   (CLK),
        .rst_n (RST_N),
        .adr_i (ADR_I),
        .dat_i (DAT_I),
        .sel_i (SEL_I),
        .we_i  (WE_I),
        .cyc_i (CYC_I),
        .stb_i (STB_I),
        .dat_o (DAT_O),
        .ack_o (ACK_O),
        .rg    (rg.bus)
    );

    logic [1:0] pins;

    // select idles high, clock idles low
    sps_sync #(.W(sps_pkg::SYNC_STAGES - 1), .RST(2'b10)) u_sync
    (
        .clk   (CLK),
        .rst_n (RST_N),
        .pin   ({SS_N_IN, SCK_IN}),
        .level (pins)
    );

    // ****************************************************************
    // control and format registers
    // ****************************************************************
    logic [7:0] control;
    logic [7:0] format;
    logic [7:0] mask;
    logic [7:0] status;
    logic       wr_ctl;
    logic       wr_fmt;
    logic       wr_stat;
    logic       wr_mask;
    logic       wr_data;
    logic       port_on_bit;
    logic       master;
    logic       clear_pending;

    assign wr_ctl  = rg.wr & (rg.idx == sps_pkg::IDX_CONTROL);
    assign wr_fmt  = rg.wr & (rg.idx == sps_pkg::IDX_FORMAT);
    assign wr_stat = rg.wr & (rg.idx == sps_pkg::IDX_STATUS);
    assign wr_mask = rg.wr & (rg.idx == sps_pkg::IDX_MASK);
    assign wr_data = rg.wr & (rg.idx == sps_pkg::IDX_DATA);

    assign port_on_bit   = control[sps_pkg::CT_EN];
    assign master        = control[sps_pkg::CT_MST];
    assign clear_pending = wr_stat & rg.wdata[sps_pkg::ST_IRQ];

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            control <= sps_pkg::CONTROL_RST;
        else if (wr_ctl)
            control <= rg.wdata;
        else if (clear_pending)
            control[sps_pkg::CT_STR] <= 1'b0;
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            format <= sps_pkg::FORMAT_RST;
        else if (wr_fmt)
            format <= rg.wdata;
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            mask <= sps_pkg::MASK_RST;
        else if (wr_mask)
            mask <= rg.wdata & sps_pkg::STICKY_BITS;
    end

    assign CONTROL_OUT = control;
    assign FORMAT_OUT  = format;

    // ****************************************************************
    // character length and serial clock edges
    // ****************************************************************
    logic [3:0] char_len;
    logic [2:0] len_field;
    logic       sck_lvl;
    logic       sck_prev;
    logic       sck_edge;
    logic       ss_n_lvl;

    assign len_field = format[sps_pkg::FM_LEN_HI:sps_pkg::FM_LEN_LO];
    assign char_len  = (len_field == 3'h0) ? sps_pkg::FULL_CHAR
                                           : {1'b0, len_field};
    assign ss_n_lvl  = pins[1];
    // idle level follows clock polarity; count leaving-idle edges
    assign sck_lvl   = pins[0] ^ control[sps_pkg::CT_POL];
    assign sck_edge  = sck_lvl & ~sck_prev;

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            sck_prev <= 1'b0;
        else
            sck_prev <= sck_lvl;
    end

    // ****************************************************************
    // slave transaction tracking
    // ****************************************************************
    sps_pkg::sps_link_t link;
    sps_pkg::sps_link_t next_link;
    logic [3:0]         bit_cnt;
    logic               slave_done;
    logic               slave_abort;
    logic               slave_on;

    assign slave_on = port_on_bit & ~master;

    always_comb
    begin
        next_link   = link;
        slave_done  = 1'b0;
        slave_abort = 1'b0;
        unique case (link)
            sps_pkg::LNK_IDLE:
            begin
                if (slave_on & ~ss_n_lvl)
                    next_link = sps_pkg::LNK_SHIFT;
            end
            sps_pkg::LNK_SHIFT:
            begin
                if (!slave_on)
                    next_link = sps_pkg::LNK_IDLE;
                else if (ss_n_lvl)
                begin
                    next_link   = sps_pkg::LNK_IDLE;
                    slave_abort = (bit_cnt != 4'h0);
                end
                else if (sck_edge && (bit_cnt + 4'h1 == char_len))
                    slave_done = 1'b1;
            end
            default:
                next_link = sps_pkg::LNK_IDLE;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            link <= sps_pkg::LNK_IDLE;
        else
            link <= next_link;
    end

    // counter restarts at each character boundary and each selection
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            bit_cnt <= 4'h0;
        else if (next_link != sps_pkg::LNK_SHIFT || slave_done)
            bit_cnt <= 4'h0;
        else if (link == sps_pkg::LNK_SHIFT && sck_edge)
            bit_cnt <= bit_cnt + 4'h1;
    end

    // ****************************************************************
    // master transfer and data register writes
    // ****************************************************************
    logic master_busy;
    logic active;
    logic data_taken;
    logic overrun;

    assign active     = master_busy | (link == sps_pkg::LNK_SHIFT);
    assign data_taken = wr_data & port_on_bit & ~active;
    assign overrun    = wr_data & port_on_bit & active;

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            master_busy <= 1'b0;
        else if (!port_on_bit || !master)
            master_busy <= 1'b0;
        else if (data_taken)
            master_busy <= 1'b1;
        else if (MASTER_DONE)
            master_busy <= 1'b0;
    end

    // the byte is forwarded only when no transfer is running
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            DATA_LOAD <= 1'b0;
            DATA_BYTE <= 8'h00;
        end
        else
        begin
            DATA_LOAD <= data_taken;
            if (data_taken)
                DATA_BYTE <= rg.wdata;
        end
    end

    // ****************************************************************
    // status flags
    // ****************************************************************
    logic [7:0] set_ev;
    logic [7:0] clr_ev;
    logic       force_ev;

    assign force_ev = wr_ctl & rg.wdata[sps_pkg::CT_STR];

    always_comb
    begin
        set_ev = 8'h00;
        clr_ev = 8'h00;
        set_ev[sps_pkg::ST_IRQ] = force_ev | (MASTER_DONE & master_busy)
                                | slave_done | slave_abort;
        set_ev[sps_pkg::ST_OVR] = overrun;
        set_ev[sps_pkg::ST_COL] = MODE_FAULT;
        set_ev[sps_pkg::ST_ABT] = slave_abort;
        // reserved bits are not stored, so writes there are harmless
        if (wr_stat)
            clr_ev = rg.wdata & sps_pkg::STICKY_BITS;
    end

    genvar g;
    generate
        for (g = 4; g < 8; g++)
        begin : g_flag
            always_ff @(posedge CLK)
            begin
                if (!RST_N)
                    status[g] <= sps_pkg::STATUS_RST[g];
                else if (!port_on_bit)
                    status[g] <= sps_pkg::STATUS_RST[g];
                else if (set_ev[g])
                    status[g] <= 1'b1;
                else if (clr_ev[g])
                    status[g] <= 1'b0;
            end
        end
    endgenerate

    assign status[3:2] = 2'b00;

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            status[sps_pkg::ST_ACT] <= sps_pkg::STATUS_RST[sps_pkg::ST_ACT];
            status[sps_pkg::ST_SEL] <= sps_pkg::STATUS_RST[sps_pkg::ST_SEL];
        end
        else if (!port_on_bit)
        begin
            status[sps_pkg::ST_ACT] <= sps_pkg::STATUS_RST[sps_pkg::ST_ACT];
            status[sps_pkg::ST_SEL] <= sps_pkg::STATUS_RST[sps_pkg::ST_SEL];
        end
        else
        begin
            status[sps_pkg::ST_ACT] <= active;
            // in master mode the pin level is shown but means nothing
            status[sps_pkg::ST_SEL] <= ss_n_lvl;
        end
    end

    // ****************************************************************
    // interrupt and read mux
    // ****************************************************************
    assign IRQ = control[sps_pkg::CT_REQUEST_FORWARD_ENABLE] & (|(status & mask));

    always_comb
    begin
        unique case (rg.idx)
            sps_pkg::IDX_DATA:    rg.rdata = SHIFT_DATA;
            sps_pkg::IDX_CONTROL: rg.rdata = control;
            sps_pkg::IDX_STATUS:  rg.rdata = status;
            sps_pkg::IDX_FORMAT:  rg.rdata = format;
            sps_pkg::IDX_MASK:    rg.rdata = mask;
            default:              rg.rdata = 8'h00;
        endcase
    end
endmodule : sps_top

/* File: sps_top_sva.sv */
`timescale 1ns/1ps
module sps_top_sva
(
    // clock and reset
    input wire logic        CLK,
    input wire logic        RST_N,
    // wishbone
    input wire logic [15:0] ADR_I,
    input wire logic [3:0]  SEL_I,
    input wire logic        WE_I,
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic [31:0] DAT_O,
    input wire logic        ACK_O,
    // link and unit
    input wire logic        SS_N_IN,
    input wire logic        DATA_LOAD,
    input wire logic [7:0]  CONTROL_OUT,
    input wire logic        IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    logic [3:0] qcnt;
    logic       ss_q;
    logic [7:0] ct_q;

    wire st_rd = ACK_O && !WE_I && ADR_I[13:2] == sps_pkg::IDX_STATUS;
    wire dw    = ACK_O && WE_I && SEL_I[0] && ADR_I[13:2] == sps_pkg::IDX_DATA;
    // pin levels need settling time through the samplers before bits track
    wire quiet = st_rd && CONTROL_OUT[1:0] == 2'b01 && qcnt > 4'h9;

    always_ff @(posedge CLK)
    begin
        ss_q <= SS_N_IN;
        ct_q <= CONTROL_OUT;
        if (!RST_N || ss_q != SS_N_IN || ct_q != CONTROL_OUT)
            qcnt <= 4'h0;
        else if (qcnt != 4'hf)
            qcnt <= qcnt + 4'h1;
    end

    sequence s_req;
        CYC_I && STB_I && !ACK_O;
    endsequence
    sequence s_off_read;
        (!CONTROL_OUT[0])[*4] ##0 st_rd;
    endsequence

    AST_ACK_NEXT: assert property (s_req |=> ACK_O)
        else $error("request not answered next cycle");
    AST_ACK_PULSE: assert property (ACK_O |=> !ACK_O)
        else $error("ack longer than one cycle");
    AST_OFF_HOLD: assert property (
        s_off_read |-> DAT_O[7:0] == sps_pkg::STATUS_RST)
        else $error("status not at reset value while port off");
    AST_OFF_QUIET: assert property ((!CONTROL_OUT[0])[*3] |-> !IRQ)
        else $error("interrupt while port off");
    AST_IRQ_GATE: assert property ((!CONTROL_OUT[7])[*2] |-> !IRQ)
        else $error("interrupt while forwarding off");
    AST_LOAD_CAUSE: assert property (
        DATA_LOAD |-> $past(dw) || $past(dw, 2))
        else $error("data load without data write");
    AST_SEL_LEVEL: assert property (quiet |-> DAT_O[0] == SS_N_IN)
        else $error("select level bit wrong");
    AST_ACTIVE: assert property (quiet |-> DAT_O[1] == !SS_N_IN)
        else $error("transfer active bit wrong");
endmodule : sps_top_sva

bind sps_top sps_top_sva chk (.CLK, .RST_N, .ADR_I, .SEL_I, .WE_I, .CYC_I,
    .STB_I, .DAT_O, .ACK_O, .SS_N_IN, .DATA_LOAD, .CONTROL_OUT, .IRQ);

/* File: sps_peer.sv */
`timescale 1ns/1ps
// external master on the link: clock stands still between frames
module sps_peer
(
    // link pins toward the block
    output logic sck,
    output logic ss_n
);
    initial
    begin
        sck = 1'b0;
        ss_n = 1'b1;
    end

    // one or more pulses, but fewer than the character length, makes an abort
    task automatic frame(input int pulses);
        #7 ss_n = 1'b0;
        #400;
        repeat (pulses)
        begin
            #80 sck = 1'b1;
            #80 sck = 1'b0;
        end
        #400 ss_n = 1'b1;
        #400;
    endtask : frame
endmodule : sps_peer

/* File: sps_top_test.sv */
`timescale 1ns/1ps
module sps_top_test;
    logic        clk, rst_n, we, cyc, stb, ack, sck, ss_n, mdone, mfault;
    logic        load, irq;
    logic [15:0] adr;
    logic [31:0] dw, dr;
    logic [3:0]  sel;
    logic [7:0]  shd, dbyte, ctl, fmt, b, loads;
    int          checks, error_cnt, cycles, n, k;

    sps_top dut (.CLK(clk), .RST_N(rst_n), .ADR_I(adr), .DAT_I(dw),
        .SEL_I(sel), .WE_I(we), .CYC_I(cyc), .STB_I(stb), .DAT_O(dr),
        .ACK_O(ack), .SCK_IN(sck), .SS_N_IN(ss_n), .MASTER_DONE(mdone),
        .MODE_FAULT(mfault), .SHIFT_DATA(shd), .DATA_LOAD(load),
        .DATA_BYTE(dbyte), .CONTROL_OUT(ctl), .FORMAT_OUT(fmt), .IRQ(irq));
    sps_peer peer (.sck(sck), .ss_n(ss_n));

    // ************************************************
    // helpers
    // ************************************************
    function automatic logic [7:0] st(input logic [3:0] f, input logic a,
                                      input logic s);
        return {f, 2'b00, a, s};
    endfunction : st

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("FAIL %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wb(input logic [11:0] i, input logic w, input logic [7:0] d,
                      output logic [7:0] r);
        @(posedge clk);
        adr <= {2'b00, i, 2'b00};
        dw <= {24'h000000, d};
        we <= w;
        sel <= 4'hf;
        cyc <= 1'b1;
        stb <= 1'b1;
        // no local limit: only the bench timeout ends a wait
        do @(posedge clk); while (ack !== 1'b1);
        r = dr[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic wr(input logic [11:0] i, input logic [7:0] d);
        logic [7:0] r;
        wb(i, 1'b1, d, r);
    endtask : wr

    task automatic rdc(input logic [11:0] i, input logic [7:0] e);
        logic [7:0] r;
        wb(i, 1'b0, 8'h00, r);
        chk(r, e);
    endtask : rdc

    task automatic fire(input logic [1:0] m);
        @(posedge clk);
        {mdone, mfault} <= m;
        @(posedge clk);
        {mdone, mfault} <= 2'b00;
    endtask : fire

    task automatic conclude;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude

    // ************************************************
    // clock, timeout, load monitor
    // ************************************************
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (load === 1'b1) loads <= loads + 8'h01;
        if (cycles == 20000)
        begin
            error_cnt++;
            conclude();
        end
    end

    // ************************************************
    // main sequence
    // ************************************************
    initial
    begin
        {rst_n, we, cyc, stb, mdone, mfault} = '0;
        adr = '0;
        dw = '0;
        sel = '0;
        loads = '0;
        void'($urandom(32'h64565b4d));
        shd = $urandom;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rdc(sps_pkg::IDX_STATUS, sps_pkg::STATUS_RST);
        rdc(sps_pkg::IDX_CONTROL, sps_pkg::CONTROL_RST);
        rdc(sps_pkg::IDX_MASK, sps_pkg::MASK_RST);
        rdc(12'hf64, 8'h00);
        rdc(sps_pkg::IDX_DATA, shd);
        wr(sps_pkg::IDX_CONTROL, 8'h40);
        rdc(sps_pkg::IDX_STATUS, st(4'h0, 1'b0, 1'b1));
        // port must already be on when the force bit is written
        wr(sps_pkg::IDX_CONTROL, 8'h01);
        wr(sps_pkg::IDX_CONTROL, 8'h41);
        rdc(sps_pkg::IDX_STATUS, st(4'h8, 1'b0, 1'b1));
        chk({7'h00, irq}, 8'h00);
        wr(sps_pkg::IDX_CONTROL, 8'hc1);
        rdc(sps_pkg::IDX_CONTROL, 8'hc1);
        chk({7'h00, irq}, 8'h01);
        wr(sps_pkg::IDX_STATUS, 8'h00);
        rdc(sps_pkg::IDX_STATUS, st(4'h8, 1'b0, 1'b1));
        wr(sps_pkg::IDX_STATUS, 8'h80);
        rdc(sps_pkg::IDX_STATUS, st(4'h0, 1'b0, 1'b1));
        rdc(sps_pkg::IDX_CONTROL, 8'h81);
        chk({7'h00, irq}, 8'h00);
        // master: second write while busy is dropped
        wr(sps_pkg::IDX_CONTROL, 8'h83);
        b = $urandom;
        wr(sps_pkg::IDX_DATA, b);
        rdc(sps_pkg::IDX_STATUS, st(4'h0, 1'b1, 1'b1));
        chk(dbyte, b);
        wr(sps_pkg::IDX_DATA, ~b);
        rdc(sps_pkg::IDX_STATUS, st(4'h4, 1'b1, 1'b1));
        chk(loads, 8'h01);
        chk({7'h00, irq}, 8'h00);
        wr(sps_pkg::IDX_MASK, 8'hff);
        rdc(sps_pkg::IDX_MASK, 8'hf0);
        chk({7'h00, irq}, 8'h01);
        wr(sps_pkg::IDX_MASK, 8'h80);
        fire(2'b10);
        rdc(sps_pkg::IDX_STATUS, st(4'hc, 1'b0, 1'b1));
        fire(2'b01);
        rdc(sps_pkg::IDX_STATUS, st(4'he, 1'b0, 1'b1));
        // set and clear meet in one cycle: set must survive
        fork
            wr(sps_pkg::IDX_STATUS, 8'h20);
            begin
                repeat (2) @(posedge clk);
                mfault <= 1'b1;
                @(posedge clk);
                mfault <= 1'b0;
            end
        join
        rdc(sps_pkg::IDX_STATUS, st(4'he, 1'b0, 1'b1));
        wr(sps_pkg::IDX_CONTROL, 8'h00);
        rdc(sps_pkg::IDX_STATUS, st(4'h0, 1'b0, 1'b1));
        fire(2'b11);
        rdc(sps_pkg::IDX_STATUS, st(4'h0, 1'b0, 1'b1));
        // slave frames, full and cut short, random lengths
        repeat (4)
        begin
            n = 2 + $urandom % 6;
            k = 1 + $urandom % (n - 1);
            wr(sps_pkg::IDX_FORMAT, n[2:0] << 2);
            wr(sps_pkg::IDX_CONTROL, 8'h01);
            chk(fmt, {3'b000, n[2:0], 2'b00});
            fork
                peer.frame(n);
                begin
                    #300;
                    rdc(sps_pkg::IDX_STATUS, st(4'h0, 1'b1, 1'b0));
                end
            join
            repeat (10) @(posedge clk);
            rdc(sps_pkg::IDX_STATUS, st(4'h8, 1'b0, 1'b1));
            wr(sps_pkg::IDX_STATUS, 8'h80);
            peer.frame(k);
            repeat (10) @(posedge clk);
            rdc(sps_pkg::IDX_STATUS, st(4'h9, 1'b0, 1'b1));
            wr(sps_pkg::IDX_STATUS, 8'h90);
            rdc(sps_pkg::IDX_STATUS, st(4'h0, 1'b0, 1'b1));
        end
        conclude();
    end
endmodule : sps_top_test
